// ===== core/adccfg_pkg.sv
// Package for the converter configuration port: register map, field positions and codes.
// Assumes a 125 MHz system clock on both ends.
`default_nettype none
package adccfg_pkg;
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 5;
  localparam int DATA_BITS = 11;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_TEST = 5'h0A;
  localparam logic [4:0] REG_IFACE = 5'h0D;
  localparam int CTRL_SWRST = 10;
  localparam int CTRL_REF = 6;
  localparam int CTRL_PDB = 3;
  localparam int CTRL_PDA = 2;
  localparam int CTRL_PDG = 0;
  localparam int TEST_PAT_LO = 5;
  localparam int IFACE_OVRD = 10;
  localparam int IFACE_GAIN = 5;
  localparam logic [10:0] RESET_VALUE = 11'h000;
  // Register write settles about 100 ns after the 16th falling edge.
  localparam int SETTLE_NS = 100;
  localparam int SYS_PERIOD_NS = 8;
  localparam int SETTLE_CYC = SETTLE_NS / SYS_PERIOD_NS;
  localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC);
  // Hardware reset wider than 10 ns must be caught: at least two sys_clk samples.
  localparam int HWRST_NS = 10;
  localparam int HWRST_CYC = (HWRST_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Host serial clock divider: reload of 4 gives a half period of 5 sys_clk, 12.5 MHz, under 20 MHz.
  localparam logic [2:0] SCLK_HALF = 3'h4;
  // Strap level codes from the comparator front end.
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_3_8 = 2'h1;
  localparam logic [1:0] LVL_5_8 = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;
  typedef enum logic [2:0] {PAT_NORMAL, PAT_SYNC, PAT_DESKEW, PAT_OTHER} adccfg_pat_t;
endpackage : adccfg_pkg
`default_nettype wire

// ===== core/adccfg_if.sv
// Serial configuration link between host and converter.
// Assumes both ends run on the same sys_clk; sclk is only sampled as data by the device.
`default_nettype none
interface adccfg_if;
  logic serial_enable_n;
  logic sclk;
  logic serial_in_bit;
  logic hw_reset;
  modport host (output serial_enable_n, output sclk, output serial_in_bit, output hw_reset);
  modport dev (input serial_enable_n, input sclk, input serial_in_bit, input hw_reset);
endinterface : adccfg_if
`default_nettype wire

// ===== core/adccfg_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to sys_clk.
`default_nettype none
module adccfg_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } adccfg_sync_st_t;
  adccfg_sync_st_t st_ff;
  adccfg_sync_st_t nxt_st;
  always_comb begin
    nxt_st.meta = pin_in;
    nxt_st.sync = st_ff.meta;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign pin_sync = st_ff.sync;
endmodule : adccfg_sync
`default_nettype wire

// ===== core/adccfg_dev.sv
// Converter end: serial register port, strap decode and pin/register priority.
// Assumes link pins and straps are asynchronous; they pass adccfg_sync before use.
//
// The register offsets and the strobed register port were decided locally.
`default_nettype none
module adccfg_dev (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Serial link
  adccfg_if.dev           link,
  // Mode: high when the three pins serve as a serial port
  input  wire logic       serial_mode,
  // Level codes for the enable pin in parallel mode and the straps
  input  wire logic [1:0] enable_level,
  input  wire logic [1:0] wire_count_strap,
  input  wire logic [1:0] serialize_edge_strap,
  input  wire logic [1:0] bit_order_format_strap,
  input  wire logic       chan_a_powerdown_strap,
  input  wire logic       chan_b_powerdown_strap,
  // Controlled functions
  output logic            chan_a_pd,
  output logic            chan_b_pd,
  output logic            global_pd,
  output logic            coarse_gain_on,
  output logic            internal_ref,
  output logic [2:0]      pattern_sel,
  output logic            ddr_clock,
  output logic            two_wire,
  output logic            ser_16x,
  output logic            capture_rising,
  output logic            lsb_first,
  output logic            offset_binary
);
  typedef struct packed {
    logic        sclk_d;
    logic [3:0]  bit_cnt;
    logic [14:0] shift;
    logic [10:0] ctrl;
    logic [10:0] test;
    logic [10:0] iface;
    logic        pend;
    logic [4:0]  pend_addr;
    logic [10:0] pend_data;
    logic [3:0]  settle;
    logic [2:0]  hw_cnt;
    logic [22:0] outs;
  } adccfg_dev_st_t;
  adccfg_dev_st_t st_ff;
  adccfg_dev_st_t nxt_st;

  logic [3:0] lnk;
  logic [9:0] straps;
  logic       sen_n;
  logic       sck;
  logic       sdi;
  logic       hwr;
  logic       mode_s;

  // Link pins oversampled, so a clock held at least two sys_clk periods in each phase works
  adccfg_sync #(.W(4)) u_link_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   ({link.serial_enable_n, link.sclk, link.serial_in_bit, link.hw_reset}),
    .pin_sync (lnk)
  );
  adccfg_sync #(.W(10)) u_strap_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   ({enable_level, wire_count_strap, serialize_edge_strap,
                bit_order_format_strap, chan_a_powerdown_strap, chan_b_powerdown_strap}),
    .pin_sync (straps)
  );
  adccfg_sync #(.W(1)) u_mode_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   (serial_mode),
    .pin_sync (mode_s)
  );
  assign sen_n = lnk[3];
  assign sck   = lnk[2];
  assign sdi   = lnk[1];
  assign hwr   = lnk[0];

  logic       fall;
  logic [1:0] s_en;
  logic [1:0] s_wc;
  logic [1:0] s_se;
  logic [1:0] s_fmt;
  logic       sel_reg;
  logic [1:0] par_pins;
  logic [22:0] o;

  always_comb begin
    nxt_st = st_ff;
    {s_en, s_wc, s_se, s_fmt} = straps[9:2];
    fall = st_ff.sclk_d & ~sck;
    nxt_st.sclk_d = sck;
    // Settle delay before a write lands
    // A word completing in this same cycle reloads the pending slot below, so it is not lost.
    if (st_ff.pend) begin
      if (st_ff.settle != 4'h0) begin
        nxt_st.settle = st_ff.settle - 4'h1;
      end else begin
        nxt_st.pend = 1'b0;
        if (st_ff.pend_addr == adccfg_pkg::REG_CTRL) begin
          nxt_st.ctrl = st_ff.pend_data;
        end else if (st_ff.pend_addr == adccfg_pkg::REG_TEST) begin
          nxt_st.test = st_ff.pend_data;
        end else if (st_ff.pend_addr == adccfg_pkg::REG_IFACE) begin
          nxt_st.iface = st_ff.pend_data;
        end
        // Software reset clears all, bit included
        if (st_ff.pend_addr == adccfg_pkg::REG_CTRL &&
            st_ff.pend_data[adccfg_pkg::CTRL_SWRST]) begin
          nxt_st.ctrl = adccfg_pkg::RESET_VALUE;
          nxt_st.test = adccfg_pkg::RESET_VALUE;
          nxt_st.iface = adccfg_pkg::RESET_VALUE;
        end
      end
    end
    if (sen_n) begin
      nxt_st.bit_cnt = 4'h0;
    end else if (fall) begin
      nxt_st.shift = {st_ff.shift[13:0], sdi};
      nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
      if (st_ff.bit_cnt == 4'hF) begin
        nxt_st.pend = 1'b1;
        nxt_st.pend_addr = st_ff.shift[14:10];
        nxt_st.pend_data = {st_ff.shift[9:0], sdi};
        nxt_st.settle = adccfg_pkg::SETTLE_CNT;
      end
    end
    // Hardware reset pulse, seen on two samples
    if (hwr) begin
      nxt_st.hw_cnt = (st_ff.hw_cnt == 3'h7) ? st_ff.hw_cnt : st_ff.hw_cnt + 3'h1;
    end else begin
      nxt_st.hw_cnt = 3'h0;
    end
    if (hwr && 32'(st_ff.hw_cnt) + 1 >= adccfg_pkg::HWRST_CYC) begin
      nxt_st.ctrl = adccfg_pkg::RESET_VALUE;
      nxt_st.test = adccfg_pkg::RESET_VALUE;
      nxt_st.iface = adccfg_pkg::RESET_VALUE;
      nxt_st.pend = 1'b0;
    end

    sel_reg = st_ff.iface[adccfg_pkg::IFACE_OVRD];
    o = '0;
    o[22] = straps[1] | st_ff.ctrl[adccfg_pkg::CTRL_PDA];
    o[21] = straps[0] | st_ff.ctrl[adccfg_pkg::CTRL_PDB];
    par_pins = {sck, sdi};
    if (mode_s) begin
      o[20] = st_ff.ctrl[adccfg_pkg::CTRL_PDG];
      o[19] = sel_reg & st_ff.iface[adccfg_pkg::IFACE_GAIN];
      o[18] = st_ff.ctrl[adccfg_pkg::CTRL_REF];
      o[17:15] = st_ff.test[adccfg_pkg::TEST_PAT_LO +: 3];
    end else begin
      o[20] = (par_pins == 2'b10);
      o[17:15] = (par_pins == 2'b01) ? adccfg_pkg::PAT_SYNC :
                 (par_pins == 2'b11) ? adccfg_pkg::PAT_DESKEW : adccfg_pkg::PAT_NORMAL;
      o[19] = (s_en == adccfg_pkg::LVL_3_8) || (s_en == adccfg_pkg::LVL_5_8);
      o[18] = (s_en == adccfg_pkg::LVL_5_8) || (s_en == adccfg_pkg::LVL_FULL);
    end
    if (sel_reg) begin
      o[14:0] = {st_ff.iface[1], st_ff.iface[0], st_ff.iface[2], st_ff.iface[4],
                 st_ff.iface[6], st_ff.iface[9:0] & 10'h000};
    end else begin
      o[14] = (s_wc != adccfg_pkg::LVL_5_8);
      o[13] = (s_wc == adccfg_pkg::LVL_5_8) || (s_wc == adccfg_pkg::LVL_FULL);
      o[12] = (s_se == adccfg_pkg::LVL_3_8) || (s_se == adccfg_pkg::LVL_5_8);
      o[11] = (s_se == adccfg_pkg::LVL_5_8) || (s_se == adccfg_pkg::LVL_FULL);
      o[10] = (s_fmt == adccfg_pkg::LVL_5_8) || (s_fmt == adccfg_pkg::LVL_FULL);
      o[9]  = (s_fmt == adccfg_pkg::LVL_3_8) || (s_fmt == adccfg_pkg::LVL_5_8);
    end
    if (sel_reg) begin
      o[9] = 1'b0;
    end
    nxt_st.outs = o;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign chan_a_pd      = st_ff.outs[22];
  assign chan_b_pd      = st_ff.outs[21];
  assign global_pd      = st_ff.outs[20];
  assign coarse_gain_on = st_ff.outs[19];
  assign internal_ref   = st_ff.outs[18];
  assign pattern_sel    = st_ff.outs[17:15];
  assign ddr_clock      = st_ff.outs[14];
  assign two_wire       = st_ff.outs[13];
  assign ser_16x        = st_ff.outs[12];
  assign capture_rising = st_ff.outs[11];
  assign lsb_first      = st_ff.outs[10];
  assign offset_binary  = st_ff.outs[9];
endmodule : adccfg_dev
`default_nettype wire

// ===== core/adccfg_host.sv
// Host end: sends 16-bit address/data words over the serial link and drives hardware reset.
// Assumes a plain register port from software on sys_clk.
`default_nettype none
module adccfg_host (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Serial link
  adccfg_if.host           link,
  // Software port
  input  wire logic [1:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata
);
  // Offsets: 0 word to send (address bits 15:11, data 10:0), 1 hardware reset pulse, 2 status.
  localparam logic [1:0] OFS_WORD = 2'h0;
  localparam logic [1:0] OFS_HWRST = 2'h1;
  localparam logic [1:0] OFS_STAT = 2'h2;
  typedef enum {H_IDLE, H_LOW, H_HIGH, H_DONE, H_RST} adccfg_hst_t;
  typedef struct packed {
    adccfg_hst_t state;
    logic [15:0] shift;
    logic [3:0]  bits;
    logic [2:0]  div;
    logic        sen_n;
    logic        sck;
    logic        sdo;
    logic        hwr;
    logic [31:0] rdata;
  } adccfg_host_st_t;
  adccfg_host_st_t st_ff;
  adccfg_host_st_t nxt_st;
  logic busy;

  always_comb begin
    nxt_st = st_ff;
    busy = (st_ff.state != H_IDLE);
    nxt_st.rdata = 32'h0000_0000;
    if (rd && addr == OFS_STAT) begin
      nxt_st.rdata = {31'h0000_0000, busy};
    end
    nxt_st.div = (st_ff.div == 3'h0) ? 3'h0 : st_ff.div - 3'h1;
    case (st_ff.state)
      H_IDLE: begin
        if (wr && addr == OFS_WORD) begin
          nxt_st.shift = wdata[15:0];
          nxt_st.sen_n = 1'b0;
          nxt_st.sck = 1'b1;
          nxt_st.sdo = wdata[15];
          nxt_st.bits = 4'h0;
          nxt_st.div = adccfg_pkg::SCLK_HALF;
          nxt_st.state = H_HIGH;
        end else if (wr && addr == OFS_HWRST) begin
          nxt_st.hwr = 1'b1;
          nxt_st.div = adccfg_pkg::SCLK_HALF;
          nxt_st.state = H_RST;
        end
      end
      H_HIGH: begin
        if (st_ff.div == 3'h0) begin
          nxt_st.sck = 1'b0;
          nxt_st.div = adccfg_pkg::SCLK_HALF;
          nxt_st.state = H_LOW;
        end
      end
      H_LOW: begin
        if (st_ff.div == 3'h0) begin
          nxt_st.sck = 1'b1;
          nxt_st.div = adccfg_pkg::SCLK_HALF;
          nxt_st.bits = st_ff.bits + 4'h1;
          nxt_st.shift = {st_ff.shift[14:0], 1'b0};
          nxt_st.sdo = st_ff.shift[14];
          nxt_st.state = (st_ff.bits == 4'hF) ? H_DONE : H_HIGH;
        end
      end
      H_DONE: begin
        if (st_ff.div == 3'h0) begin
          nxt_st.sen_n = 1'b1;
          nxt_st.state = H_IDLE;
        end
      end
      default: begin
        if (st_ff.div == 3'h0) begin
          nxt_st.hwr = 1'b0;
          nxt_st.state = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{state: H_IDLE, shift: 16'h0000, bits: 4'h0, div: 3'h0, sen_n: 1'b1,
                 sck: 1'b1, sdo: 1'b0, hwr: 1'b0, rdata: 32'h0000_0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.serial_enable_n = st_ff.sen_n;
  assign link.sclk            = st_ff.sck;
  assign link.serial_in_bit   = st_ff.sdo;
  assign link.hw_reset        = st_ff.hwr;
  assign rdata                = st_ff.rdata;
endmodule : adccfg_host
`default_nettype wire

// ===== dv/adccfg_monitor.sv
// Checker for the serial configuration link between host and device ends.
// Assumes it watches the link that joins two design ends, all on sys_clk.
`default_nettype none
module adccfg_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link signals
  input wire logic serial_enable_n,
  input wire logic sclk,
  input wire logic serial_in_bit,
  input wire logic hw_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] fall_cnt_ff;
  logic [5:0] nxt_fall_cnt;
  logic       sclk_ff;
  // Falling edges are counted per frame so the word length can be judged at frame end.
  always_comb begin
    nxt_fall_cnt = serial_enable_n ? 6'h00 : fall_cnt_ff + 6'(sclk_ff & !sclk);
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_cnt_ff <= 6'h00;
      sclk_ff     <= 1'b1;
    end else begin
      fall_cnt_ff <= nxt_fall_cnt;
      sclk_ff     <= sclk;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  idle_clock_high_a: assert property (serial_enable_n |-> sclk)
    else $error("serial clock low outside a frame");
  enable_setup_a: assert property ($fell(serial_enable_n) |-> sclk [*4])
    else $error("serial clock fell too soon after enable");
  enable_hold_a: assert property ($rose(serial_enable_n) |-> $past(sclk, 3))
    else $error("enable released too soon after clock");
  sclk_rate_a: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("serial clock faster than allowed");
  data_steady_a: assert property ($fell(sclk) |-> $stable(serial_in_bit))
    else $error("data moved at the sampling edge");
  word_length_a: assert property ($rose(serial_enable_n) |-> fall_cnt_ff == 6'h10)
    else $error("frame did not carry one whole word");
  frame_bound_a: assert property ($fell(serial_enable_n) |-> ##[100:400] serial_enable_n)
    else $error("frame did not end in time");
  hw_pulse_a: assert property ($rose(hw_reset) |=> hw_reset)
    else $error("hardware reset pulse too short");
  hw_release_a: assert property ($rose(hw_reset) |-> ##[1:200] !hw_reset)
    else $error("hardware reset not returned low");
  hw_quiet_a: assert property (hw_reset |-> serial_enable_n)
    else $error("frame sent during hardware reset");
endmodule : adccfg_monitor
`default_nettype wire

// ===== dv/adc_config_serial_and_pin_control_tb.sv
// Bench: host and device joined by the link, plus a spare device end driven directly.
// Assumes the package, interface and design ends under core/ are compiled first.
`default_nettype none
module adc_config_serial_and_pin_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] CTRL = adccfg_pkg::REG_CTRL;
  localparam logic [4:0] TEST = adccfg_pkg::REG_TEST;
  localparam logic [4:0] IFC = adccfg_pkg::REG_IFACE;
  localparam logic [10:0] DEF = adccfg_pkg::RESET_VALUE;
  localparam logic [4:0] ADDRS [4] = '{CTRL, TEST, IFC, 5'h1F};
  logic            sys_clk;
  logic            rst_n;
  logic [1:0]      addr;
  logic [31:0]     wdata;
  logic            wr;
  logic            rd;
  logic [31:0]     rdata;
  logic            serial_mode;
  logic [1:0]      enable_level;
  logic [1:0]      wire_count_strap;
  logic [1:0]      serialize_edge_strap;
  logic [1:0]      bit_order_format_strap;
  logic            pda;
  logic            pdb;
  wire logic [13:0] outs;
  wire logic [13:0] outs2;
  logic [10:0]     m_ctrl;
  logic [10:0]     m_test;
  logic [10:0]     m_ifc;
  int              err_count;
  int              samples_checked;
  adccfg_if lk ();
  adccfg_if lk2 ();
  adccfg_host adccfg_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(lk.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  adccfg_dev adccfg_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(lk.dev),
    .serial_mode(serial_mode), .enable_level(enable_level), .wire_count_strap(wire_count_strap),
    .serialize_edge_strap(serialize_edge_strap), .bit_order_format_strap(bit_order_format_strap),
    .chan_a_powerdown_strap(pda), .chan_b_powerdown_strap(pdb), .chan_a_pd(outs[13]),
    .chan_b_pd(outs[12]), .global_pd(outs[11]), .coarse_gain_on(outs[10]),
    .internal_ref(outs[9]), .pattern_sel(outs[8:6]), .ddr_clock(outs[5]), .two_wire(outs[4]),
    .ser_16x(outs[3]), .capture_rising(outs[2]), .lsb_first(outs[1]), .offset_binary(outs[0]));
  adccfg_dev adccfg_dev_spare_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(lk2.dev),
    .serial_mode(serial_mode), .enable_level(enable_level), .wire_count_strap(wire_count_strap),
    .serialize_edge_strap(serialize_edge_strap), .bit_order_format_strap(bit_order_format_strap),
    .chan_a_powerdown_strap(pda), .chan_b_powerdown_strap(pdb), .chan_a_pd(outs2[13]),
    .chan_b_pd(outs2[12]), .global_pd(outs2[11]), .coarse_gain_on(outs2[10]),
    .internal_ref(outs2[9]), .pattern_sel(outs2[8:6]), .ddr_clock(outs2[5]),
    .two_wire(outs2[4]), .ser_16x(outs2[3]), .capture_rising(outs2[2]), .lsb_first(outs2[1]),
    .offset_binary(outs2[0]));
  adccfg_monitor adccfg_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .serial_enable_n(lk.serial_enable_n), .sclk(lk.sclk), .serial_in_bit(lk.serial_in_bit),
    .hw_reset(lk.hw_reset));

  // In parallel mode pp is the clock/data pin pair; the idle host holds it at high/low.
  function automatic logic [13:0] expect_out(input logic [10:0] c, t, f, input logic [1:0] pp);
    logic [13:0] e;
    e[13] = pda | c[2];
    e[12] = pdb | c[3];
    e[11] = serial_mode ? c[0] : (pp == 2'b10);
    e[10] = serial_mode ? f[10] & f[5] : ^enable_level;
    e[9] = serial_mode ? c[6] : enable_level[1];
    e[8:6] = serial_mode ? t[7:5] : (pp == 2'b01) ? 3'h1 : (pp == 2'b11) ? 3'h2 : 3'h0;
    e[5:0] = f[10] ? {f[1], f[0], f[2], f[4], f[6], 1'b0} :
      {wire_count_strap != 2'h2, wire_count_strap != 2'h0, ^serialize_edge_strap,
       serialize_edge_strap[1], bit_order_format_strap[1], ^bit_order_format_strap};
    return e;
  endfunction : expect_out

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic bus(input logic [1:0] a, input logic [31:0] d, input logic w);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic read_reg(input logic [1:0] a, output logic [31:0] d);
    bus(a, 32'h0000_0000, 1'b0);
    #1 d = rdata;
  endtask : read_reg

  task automatic wait_idle();
    logic [31:0] s;
    for (int i = 0; i < 200; i++) begin
      read_reg(2'h2, s);
      if (s[0] === 1'b0) return;
    end
    check("busy wait", 32'h0000_0001, 32'h0000_0000);
    tally_and_finish();
  endtask : wait_idle

  task automatic settle_check(input string what);
    repeat (30) @(posedge sys_clk);
    #1;
    check(what, 32'(outs), 32'(expect_out(m_ctrl, m_test, m_ifc, 2'b10)));
  endtask : settle_check

  // Offset 1 pulses hardware reset; a set top bit in the control word is a software reset.
  task automatic op(input logic [1:0] off, input logic [15:0] w);
    bus(off, {16'h0000, w}, 1'b1);
    wait_idle();
    if (off == 2'h1 || (w[15:11] == CTRL && w[adccfg_pkg::CTRL_SWRST])) begin
      m_ctrl = DEF;
      m_test = DEF;
      m_ifc = DEF;
    end else if (w[15:11] == CTRL) m_ctrl = w[10:0];
    else if (w[15:11] == TEST) m_test = w[10:0];
    else if (w[15:11] == IFC) m_ifc = w[10:0];
    settle_check("outputs after write");
  endtask : op

  // The spare link clock runs at 64 ns only inside frames; data is inverted once released.
  task automatic raw_frame(input logic [47:0] bits, input int n);
    #13 lk2.serial_enable_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      lk2.serial_in_bit = bits[i];
      #32 lk2.sclk = 1'b0;
      #32 lk2.sclk = 1'b1;
    end
    #32 lk2.serial_enable_n = 1'b1;
    lk2.serial_in_bit = !lk2.serial_in_bit;
    repeat (30) @(posedge sys_clk);
    #1;
  endtask : raw_frame

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    #400_000;
    check("run time", 32'h0000_0001, 32'h0000_0000);
    tally_and_finish();
  end

  initial begin
    logic [10:0] d1;
    logic [10:0] d2;
    logic [31:0] v;
    void'($urandom(32'h1155));
    {rst_n, addr, wdata, wr, rd, serial_mode, enable_level, pda, pdb} = '0;
    {wire_count_strap, serialize_edge_strap, bit_order_format_strap} = '0;
    {lk2.serial_enable_n, lk2.sclk, lk2.serial_in_bit, lk2.hw_reset} = 4'hC;
    {m_ctrl, m_test, m_ifc} = {DEF, DEF, DEF};
    err_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      enable_level <= 2'(i);
      wire_count_strap <= (i == 1) ? 2'h2 : 2'(i);
      serialize_edge_strap <= 2'(3 - i);
      bit_order_format_strap <= 2'(i);
      lk2.sclk <= i[1];
      lk2.serial_in_bit <= i[0];
      settle_check("parallel decode");
      check("parallel pin pair", 32'(outs2), 32'(expect_out(DEF, DEF, DEF, 2'(i))));
      @(posedge sys_clk);
    end
    lk2.sclk <= 1'b1;
    lk2.serial_in_bit <= 1'b0;
    serial_mode <= 1'b1;
    op(2'h1, 16'h0001);
    op(2'h0, {IFC, 11'h477});
    op(2'h0, {CTRL, 11'h04D});
    op(2'h0, {TEST, 11'h0E0});
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      pda <= 1'($urandom);
      pdb <= 1'($urandom);
      wire_count_strap <= 2'h2 | 2'($urandom);
      serialize_edge_strap <= 2'($urandom);
      bit_order_format_strap <= 2'($urandom);
      op(2'h0, {ADDRS[i % 4], 11'($urandom)});
    end
    op(2'h0, {CTRL, 11'h3FF});
    op(2'h0, {CTRL, 11'h400});
    op(2'h0, {IFC, 11'h7FF});
    op(2'h1, 16'h0001);
    bus(2'h0, {16'h0000, TEST, 11'h0C0}, 1'b1);
    bus(2'h0, {16'h0000, TEST, 11'h020}, 1'b1);
    wait_idle();
    m_test = 11'h0C0;
    settle_check("second write while busy");
    read_reg(2'h3, v);
    check("unmapped offset read", v, 32'h0000_0000);
    d1 = 11'($urandom);
    d2 = 11'($urandom) | 11'h400;
    raw_frame({8'h00, TEST, d1, IFC, d2, 8'h55}, 40);
    check("two words and a tail", 32'(outs2), 32'(expect_out(DEF, d1, d2, 2'b10)));
    d1 = 11'($urandom);
    raw_frame({17'h0_0000, TEST, d1, TEST, 10'h3FF}, 31);
    check("word and fifteen bits", 32'(outs2), 32'(expect_out(DEF, d1, d2, 2'b10)));
    tally_and_finish();
  end
endmodule : adc_config_serial_and_pin_control_tb
`default_nettype wire
